/* pkg/kdrf_defs.svh */
`ifndef KDRF_DEFS_SVH
`define KDRF_DEFS_SVH

// Register byte offsets on the bus
`define KDRF_ADDR_W          6
`define KDRF_REG_CTRL        6'h00
`define KDRF_REG_NLIM        6'h04
`define KDRF_REG_PLIM        6'h08
`define KDRF_REG_NTIME       6'h0C
`define KDRF_REG_PTIME       6'h10
`define KDRF_REG_KEY         6'h14
`define KDRF_REG_STAT        6'h18
`define KDRF_REG_IRQ         6'h1C
`define KDRF_REG_MASK        6'h20

// Control register fields
`define KDRF_CTRL_EN         0
`define KDRF_CTRL_SEND       1
`define KDRF_CTRL_AUTO       2

// Reset values
`define KDRF_CTRL_RST        3'h1
`define KDRF_NLIM_RST        7'h14
`define KDRF_PLIM_RST        7'h14
`define KDRF_NTIME_RST       8'h14
`define KDRF_PTIME_RST       8'h14
`define KDRF_KEY_RST         6'h00
`define KDRF_KEY_MAX         6'h2F

// Interrupt status bits
`define KDRF_IRQ_W           4
`define KDRF_IRQ_NEG         0
`define KDRF_IRQ_POS         1
`define KDRF_IRQ_DRIFT       2
`define KDRF_IRQ_SENT        3

// Record layout
`define KDRF_REC_LAST        4'h8
`define KDRF_FRAME_BASE      9'h012
`define KDRF_KEY_GROUPS      9'h006
`define KDRF_LIM_BIT         13
`define KDRF_DET_BIT         14
`define KDRF_GAIN_BIT        15
`define KDRF_DRIFT_MAX       8'sh7F
`define KDRF_DRIFT_MIN       8'sh81

// Timing
`define KDRF_CLK_KHZ         200000
`define KDRF_DRIFT_UNIT_MS   100
`define KDRF_DETECT_UNIT_MS  500
`define KDRF_DRIFT_UNIT_CYC  (`KDRF_DRIFT_UNIT_MS * `KDRF_CLK_KHZ)
`define KDRF_DET_PER_DRIFT   (`KDRF_DETECT_UNIT_MS / `KDRF_DRIFT_UNIT_MS)

`endif

/* pkg/kdrf_pkg.sv */
`include "kdrf_defs.svh"

package kdrf_pkg;

    typedef logic [7:0] kdrf_byte_t;

    // One key's diagnostic record before byte packing
    typedef struct packed {
        logic [15:0] word0;
        logic [15:0] word1;
        logic [7:0]  normal_di;
        logic [7:0]  fast_di;
        logic [7:0]  neg_time;
        logic [7:0]  pos_time;
        logic [7:0]  drift;
    } kdrf_rec_s;

    typedef enum logic {kdrf_ser_idle, kdrf_ser_send} kdrf_ser_e;

    // Frame byte where a key's record starts; keys interleave by k mod 8
    function automatic logic [8:0] kdrf_rec_base(input logic [5:0] key);
        logic [8:0] slot;
        slot = {6'h00, key[2:0]} * `KDRF_KEY_GROUPS + {6'h00, key[5:3]};
        return `KDRF_FRAME_BASE + slot * 9'h009;
    endfunction : kdrf_rec_base

    // Byte n of a record, low byte of each word first
    function automatic kdrf_byte_t kdrf_rec_byte(input kdrf_rec_s r,
                                                 input logic [3:0] n);
        case (n)
            4'h0:    return r.word0[7:0];
            4'h1:    return r.word0[15:8];
            4'h2:    return r.word1[7:0];
            4'h3:    return r.word1[15:8];
            4'h4:    return r.normal_di;
            4'h5:    return r.fast_di;
            4'h6:    return r.neg_time;
            4'h7:    return r.pos_time;
            default: return r.drift;
        endcase
    endfunction : kdrf_rec_byte

endpackage : kdrf_pkg

/* pkg/kdrf_rec_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface kdrf_rec_if;
    import kdrf_pkg::*;

    logic                start;
    kdrf_rec_s           rec;
    logic [5:0]          key;
    logic                busy;
    logic                done;
    kdrf_byte_t          data;
    logic                valid;
    logic                ready;
    logic [8:0]          pos;
    logic                last;

    modport ctrl (output start, rec, key, ready,
                  input  busy, done, data, valid, pos, last);
    modport ser  (input  start, rec, key, ready,
                  output busy, done, data, valid, pos, last);
endinterface : kdrf_rec_if

`default_nettype wire

/* verification/kdrf_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// Bus, record stream and recal timing seen at the top ports
module kdrf_properties (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_ack_o,
    input  wire logic [12:0]          meas_signal,
    input  wire logic                 recal,
    input  wire kdrf_pkg::kdrf_byte_t rec_data,
    input  wire logic                 rec_valid,
    input  wire logic                 rec_ready,
    input  wire logic [8:0]           rec_pos,
    input  wire logic                 rec_last
);
    import kdrf_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    AST_ACK_NEXT: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack in next cycle");
    AST_BYTE_HOLD: assert property (
        rec_valid && !rec_ready |=> rec_valid && $stable(rec_data)
        && $stable(rec_pos) && $stable(rec_last))
        else $error("record byte changed while stalled");
    AST_POS_STEP: assert property (
        rec_valid && rec_ready && !rec_last
        |=> rec_valid && rec_pos == $past(rec_pos) + 9'h001)
        else $error("record bytes not consecutive");
    AST_LAST_GAP: assert property (
        rec_valid && rec_ready && rec_last |=> !rec_valid)
        else $error("no idle cycle after the last byte");
    AST_REC_BASE: assert property (
        $rose(rec_valid) |-> rec_pos >= 9'h012 && rec_pos <= 9'h1B9
        && (rec_pos - 9'h012) % 9'h009 == 9'h000)
        else $error("record starts off a slot boundary");
    AST_SIG_LOW: assert property (
        $rose(rec_valid) |-> rec_data == $past(meas_signal[7:0]))
        else $error("byte 0 is not signal low");
    AST_RECAL_ONE: assert property (recal |=> !recal)
        else $error("recal longer than one cycle");

    // Main scenarios reached
    cover property ($rose(rec_valid));
    cover property (rec_valid && !rec_ready);
    cover property (recal);
endmodule : kdrf_properties

`default_nettype wire

/* verification/kdrf_sink.sv */
`timescale 1ns/1ps
`default_nettype none

// Debug tool taking the record stream; keeps the last record's bytes
module kdrf_sink (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 slow,
    input  wire kdrf_pkg::kdrf_byte_t rec_data,
    input  wire logic                 rec_valid,
    input  wire logic [8:0]           rec_pos,
    input  wire logic                 rec_last,
    output logic                      rec_ready,
    output kdrf_pkg::kdrf_byte_t      got [9],
    output logic [8:0]                base,
    output logic [7:0]                nrec
);
    import kdrf_pkg::*;
    logic [3:0] idx;

    // Slow mode stalls every other cycle, like a busy host link
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_ready <= 1'h1;
            idx       <= 4'h0;
            base      <= 9'h000;
            nrec      <= 8'h00;
        end else begin
            rec_ready <= slow ? ~rec_ready : 1'h1;
            if (rec_valid && rec_ready) begin
                got[idx] <= rec_data;
                if (idx == 4'h0) base <= rec_pos;
                idx <= rec_last ? 4'h0 : idx + 4'h1;
                if (rec_last) nrec <= nrec + 8'h01;
            end
        end
    end
endmodule : kdrf_sink

`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import kdrf_pkg::*;

    typedef struct {
        logic [5:0]  key;
        logic [12:0] sig;
        logic [2:0]  cal;
        logic [12:0] rv;
        logic [2:0]  flg;
        logic [7:0]  ndi;
        logic [3:0]  fdi;
    } kdrf_row_s;

    // Keys spread over the interleave, calibration states 0 to 6 once each
    kdrf_row_s rows [7] = '{
        '{6'h00, 13'h1A5C, 3'h0, 13'h0F0F, 3'h0, 8'h12, 4'h3},
        '{6'h08, 13'h0001, 3'h1, 13'h1FFF, 3'h1, 8'hFF, 4'hF},
        '{6'h01, 13'h1FFF, 3'h2, 13'h0000, 3'h2, 8'h00, 4'h0},
        '{6'h2F, 13'h0ABC, 3'h3, 13'h1234, 3'h4, 8'h5A, 4'h9},
        '{6'h07, 13'h1000, 3'h4, 13'h0800, 3'h7, 8'hA5, 4'h6},
        '{6'h28, 13'h00FF, 3'h5, 13'h1100, 3'h5, 8'h3C, 4'hC},
        '{6'h17, 13'h1F00, 3'h6, 13'h00FF, 3'h3, 8'hC3, 4'h1}};
    logic [5:0]  ra [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14,
                             6'h18, 6'h1C, 6'h20, 6'h3C};
    logic [31:0] rr [10] = '{32'h1, 32'h14, 32'h14, 32'h14, 32'h14, 32'h0,
                             32'h00141400, 32'h0, 32'h0, 32'h0};

    logic        clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0;
    logic        we = 1'h0, ndet = 1'h0, pdet = 1'h0, slow = 1'h0;
    logic        dup = 1'h1, ddn = 1'h1;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wdat = 32'h0;
    logic [12:0] sig = 13'h0, rv = 13'h0;
    logic [2:0]  cal = 3'h0, flg = 3'h0;
    logic [7:0]  ndi = 8'h0;
    logic [3:0]  fdi = 4'h0;
    logic        ack, irq, recal, rvalid, rready, rlast;
    logic [31:0] rdat, q;
    logic [8:0]  rpos, base;
    logic [7:0]  nrec;
    kdrf_byte_t  rdata;
    kdrf_byte_t  got [9];
    int          num_errors = 0;
    int          checked = 0;

    always #2.5 clk = ~clk;

    kdrf_top #(.DRIFT_UNIT_CYC(10)) i_dut ( // 100 ms tick as 10 cycles
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .meas_signal(sig),
        .cal_state(cal), .ref_value(rv), .signal_limit_fail(flg[0]),
        .key_detect(flg[1]), .key_gain_test_fail(flg[2]), .normal_di(ndi),
        .fast_di(fdi), .neg_detect(ndet), .pos_detect(pdet),
        .drift_up(dup), .drift_down(ddn), .recal(recal), .rec_data(rdata),
        .rec_valid(rvalid), .rec_ready(rready), .rec_pos(rpos),
        .rec_last(rlast));

    kdrf_sink i_sink (
        .clk(clk), .rst_n(rst_n), .slow(slow), .rec_data(rdata),
        .rec_valid(rvalid), .rec_pos(rpos), .rec_last(rlast),
        .rec_ready(rready), .got(got), .base(base), .nrec(nrec));

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, exp, input string what);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    task automatic timeout(input string what);
        num_errors++;
        $display("mismatch at %0t: no answer from %s", $time, what);
        give_verdict();
    endtask : timeout

    // Classic single cycle; released only after the ack edge
    task automatic wb(input logic w, logic [5:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (n >= 20) timeout("bus");
    endtask : wb

    task automatic send(input logic [5:0] k);
        int n = 0;
        logic [7:0] n0 = nrec;
        wb(1'h1, 6'h14, 32'(k));
        wb(1'h1, 6'h00, 32'h3);
        while (nrec === n0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) timeout("record");
    endtask : send

    task automatic wait_recal(input int lim, output int n);
        n = 0;
        while (recal !== 1'h1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) timeout("recal");
    endtask : wait_recal

    initial begin
        kdrf_row_s r;
        kdrf_byte_t e [9];
        int n;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        // Ordinary records; odd rows stall the stream
        foreach (rows[i]) begin
            r = rows[i];
            sig <= r.sig;
            cal <= r.cal;
            rv <= r.rv;
            flg <= r.flg;
            ndi <= r.ndi;
            fdi <= r.fdi;
            slow <= i[0];
            send(r.key);
            e = '{r.sig[7:0], {r.cal, r.sig[12:8]}, r.rv[7:0],
                  {r.flg, r.rv[12:8]}, r.ndi, {4'h0, r.fdi}, 8'h14, 8'h14,
                  8'h00};
            for (int j = 0; j < 9; j++)
                check(32'(got[j]), 32'(e[j]), "rx");
            check(32'(base), 32'(18 + 9 * ((r.key % 8) * 6 + r.key / 8)),
                  "base");
        end
        // Reset in mid-run, then every register and a hole read back
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        foreach (ra[i]) begin
            wb(1'h0, ra[i], 32'h0);
            check(q, rr[i], "reset value");
        end
        wb(1'h1, 6'h14, 32'h05);
        wb(1'h1, 6'h14, 32'h30);
        wb(1'h0, 6'h14, 32'h0);
        check(q, 32'h05, "key 48 refused");
        // A send while busy is dropped; the sent flag waits behind its mask
        slow <= 1'h1;
        n = int'(nrec);
        wb(1'h1, 6'h00, 32'h3);
        wb(1'h0, 6'h18, 32'h0);
        check(32'(q[24]), 32'h1, "busy");
        wb(1'h1, 6'h00, 32'h3);
        repeat (60) @(posedge clk);
        check(32'(nrec), 32'(n + 1), "one record");
        check(32'(base), 32'h120, "key 5 base");
        wb(1'h0, 6'h1C, 32'h0);
        check(q, 32'h8, "sent flag");
        check(32'(irq), 32'h0, "masked");
        wb(1'h1, 6'h20, 32'h8);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h1, "unmasked");
        wb(1'h1, 6'h1C, 32'h8);
        wb(1'h0, 6'h1C, 32'h0);
        check(q, 32'h0, "cleared");
        check(32'(irq), 32'h0, "irq dropped");
        // Drift reaching each limit recalibrates and clears the count
        wb(1'h1, 6'h08, 32'h3);
        wb(1'h1, 6'h04, 32'h2);
        for (int d = 0; d < 2; d++) begin
            dup <= ~d[0];
            ddn <= d[0];
            wait_recal(100, n);
            dup <= 1'h1;
            ddn <= 1'h1;
            check(32'(n > 10 * (2 - d)), 32'h1, "drift limit");
            wb(1'h0, 6'h18, 32'h0);
            check(32'(q[7:0]), 32'h0, "drift cleared");
            wb(1'h0, 6'h1C, 32'h0);
            check(32'(q[2]), 32'h1, "drift flag");
        end
        // Limit off: the count saturates at -127
        wb(1'h1, 6'h04, 32'h0);
        dup <= 1'h0;
        repeat (1400) @(posedge clk);
        dup <= 1'h1;
        wb(1'h0, 6'h18, 32'h0);
        check(32'(q[7:0]), 32'h81, "drift floor");
        send(6'h00);
        check(32'(got[8]), 32'h81, "drift byte");
        // Detect timers expire after two 500 ms units
        wb(1'h1, 6'h1C, 32'hF);
        for (int t = 0; t < 2; t++) begin
            wb(1'h1, t[0] ? 6'h10 : 6'h0C, 32'h2);
            ndet <= ~t[0];
            pdet <= t[0];
            wait_recal(200, n);
            ndet <= 1'h0;
            pdet <= 1'h0;
            check(32'(n > 45 && n < 110), 32'h1, "detect time");
            wb(1'h0, 6'h1C, 32'h0);
            check(q, 32'(1 << t), "detect flag");
            wb(1'h1, 6'h1C, 32'hF);
        end
        give_verdict();
    end
endmodule : testbench

bind kdrf_top kdrf_properties i_props (.*);

`default_nettype wire

/* verilog/kdrf_ser.sv */
`timescale 1ns/1ps
`default_nettype none

// Shifts one latched record out as nine frame bytes
module kdrf_ser
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    kdrf_rec_if.ser     rif
);
    import kdrf_pkg::*;

    kdrf_ser_e   state;
    kdrf_ser_e   next_state;
    kdrf_rec_s   shadow;
    kdrf_rec_s   next_shadow;
    logic [3:0]  idx;
    logic [3:0]  next_idx;
    kdrf_byte_t  data;
    kdrf_byte_t  next_data;
    logic [8:0]  pos;
    logic [8:0]  next_pos;
    logic        valid;
    logic        next_valid;
    logic        done;
    logic        next_done;
    logic        last;
    logic        next_last;

    // Sequencer; a start while busy is dropped so one record stays coherent
    always_comb begin
        next_state  = state;
        next_shadow = shadow;
        next_idx    = idx;
        next_data   = data;
        next_pos    = pos;
        next_valid  = valid;
        next_done   = 1'b0;
        case (state)
            kdrf_ser_idle: begin
                if (rif.start) begin
                    next_state  = kdrf_ser_send;
                    next_shadow = rif.rec;
                    next_idx    = 4'h0;
                    next_data   = kdrf_rec_byte(rif.rec, 4'h0);
                    next_pos    = kdrf_rec_base(rif.key);
                    next_valid  = 1'b1;
                end
            end
            kdrf_ser_send: begin
                if (rif.ready) begin
                    if (idx == `KDRF_REC_LAST) begin
                        next_state = kdrf_ser_idle;
                        next_valid = 1'b0;
                        next_done  = 1'b1;
                    end else begin
                        next_idx  = idx + 4'h1;
                        next_data = kdrf_rec_byte(shadow, idx + 4'h1);
                        next_pos  = pos + 9'h001;
                    end
                end
            end
            default: begin
                next_state = kdrf_ser_idle;
                next_valid = 1'b0;
            end
        endcase
        next_last = next_valid && (next_idx == `KDRF_REC_LAST);
    end

    // Registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state  <= kdrf_ser_idle;
            shadow <= '0;
            idx    <= 4'h0;
            data   <= 8'h00;
            pos    <= 9'h000;
            valid  <= 1'b0;
            done   <= 1'b0;
            last   <= 1'b0;
        end else begin
            state  <= next_state;
            shadow <= next_shadow;
            idx    <= next_idx;
            data   <= next_data;
            pos    <= next_pos;
            valid  <= next_valid;
            done   <= next_done;
            last   <= next_last;
        end
    end

    assign rif.busy  = (state != kdrf_ser_idle);
    assign rif.done  = done;
    assign rif.data  = data;
    assign rif.valid = valid;
    assign rif.pos   = pos;
    assign rif.last  = last;

endmodule : kdrf_ser

`default_nettype wire

/* verilog/kdrf_top.sv */
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module kdrf_top
#(
    parameter int unsigned DRIFT_UNIT_CYC = `KDRF_DRIFT_UNIT_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [`KDRF_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         irq,
    input  wire logic [12:0]             meas_signal,
    input  wire logic [2:0]              cal_state,
    input  wire logic [12:0]             ref_value,
    input  wire logic                    signal_limit_fail,
    input  wire logic                    key_detect,
    input  wire logic                    key_gain_test_fail,
    input  wire logic [7:0]              normal_di,
    input  wire logic [3:0]              fast_di,
    input  wire logic                    neg_detect,
    input  wire logic                    pos_detect,
    input  wire logic                    drift_up,
    input  wire logic                    drift_down,
    output logic                         recal,
    output kdrf_pkg::kdrf_byte_t         rec_data,
    output logic                         rec_valid,
    input  wire logic                    rec_ready,
    output logic [8:0]                   rec_pos,
    output logic                         rec_last
);
    import kdrf_pkg::*;

    localparam int unsigned DET_TICKS = `KDRF_DET_PER_DRIFT;

    kdrf_rec_if rif ();

    // Bus and register state
    logic                 ack;
    logic                 next_ack;
    logic [31:0]          rdata;
    logic [31:0]          next_rdata;
    logic [2:0]           ctrl;
    logic [2:0]           next_ctrl;
    logic [6:0]           nlim;
    logic [6:0]           next_nlim;
    logic [6:0]           plim;
    logic [6:0]           next_plim;
    logic [7:0]           det_reload [2];
    logic [7:0]           next_det_reload [2];
    logic [5:0]           key;
    logic [5:0]           next_key;
    logic [`KDRF_IRQ_W-1:0] istat;
    logic [`KDRF_IRQ_W-1:0] next_istat;
    logic [`KDRF_IRQ_W-1:0] imask;
    logic [`KDRF_IRQ_W-1:0] next_imask;
    logic                 irq_q;
    logic                 next_irq;
    logic                 req;
    logic                 wr;

    // Tick and key state
    logic [31:0]          div;
    logic [31:0]          next_div;
    logic [2:0]           sub;
    logic [2:0]           next_sub;
    logic                 tick100;
    logic                 tick500;
    logic [7:0]           det_time [2];
    logic [7:0]           next_det_time [2];
    logic [1:0]           expire;
    logic [1:0]           det_active;
    logic signed [7:0]    drift;
    logic signed [7:0]    next_drift;
    logic                 drift_hit;
    logic                 any_hit;
    logic                 recal_q;
    logic [`KDRF_IRQ_W-1:0] events;

    assign req = wb_cyc_i && wb_stb_i && !ack;
    assign wr  = req && wb_we_i && wb_sel_i[0];

    // Time base: 100 ms enable, every fifth one also a 500 ms enable
    assign tick100 = ctrl[`KDRF_CTRL_EN] && (div == DRIFT_UNIT_CYC - 1);
    assign tick500 = tick100 && (sub == 3'(DET_TICKS - 1));
    always_comb begin
        next_div = div;
        next_sub = sub;
        if (!ctrl[`KDRF_CTRL_EN]) begin
            next_div = 32'h0000_0000;
        end else if (tick100) begin
            next_div = 32'h0000_0000;
            next_sub = tick500 ? 3'h0 : sub + 3'h1;
        end else begin
            next_div = div + 32'h0000_0001;
        end
    end

    // Detect timers: reload while idle or after any recalibration
    assign det_active = {pos_detect, neg_detect};
    generate
        for (genvar i = 0; i < 2; i++) begin : g_det
            assign expire[i] = det_active[i] && tick500 &&
                               (det_time[i] <= 8'h01);
            always_comb begin
                if (!det_active[i] || any_hit) begin
                    next_det_time[i] = det_reload[i];
                end else if (tick500 && det_time[i] != 8'h00) begin
                    next_det_time[i] = det_time[i] - 8'h01;
                end else begin
                    next_det_time[i] = det_time[i];
                end
            end
        end
    endgenerate

    // Drift counter; a zero limit disables that direction
    assign drift_hit = ((plim != 7'h00) &&
                        (drift >= $signed({1'b0, plim}))) ||
                       ((nlim != 7'h00) &&
                        (drift <= -$signed({1'b0, nlim})));
    assign any_hit = drift_hit || (|expire);
    always_comb begin
        next_drift = drift;
        if (any_hit) begin
            next_drift = 8'sh00;
        end else if (tick100 && drift_up && !drift_down) begin
            if (drift != `KDRF_DRIFT_MAX) next_drift = drift + 8'sh01;
        end else if (tick100 && drift_down && !drift_up) begin
            if (drift != `KDRF_DRIFT_MIN) next_drift = drift - 8'sh01;
        end
    end

    // Record assembly from live inputs; the serializer snapshots it
    always_comb begin
        rif.rec.word0     = {cal_state, meas_signal};
        rif.rec.word1     = {key_gain_test_fail, key_detect,
                             signal_limit_fail, ref_value};
        rif.rec.normal_di = normal_di;
        rif.rec.fast_di   = {4'h0, fast_di};
        rif.rec.neg_time  = det_time[0];
        rif.rec.pos_time  = det_time[1];
        rif.rec.drift     = drift;
    end
    assign rif.start = (wr && wb_adr_i == `KDRF_REG_CTRL &&
                        wb_dat_i[`KDRF_CTRL_SEND]) ||
                       (ctrl[`KDRF_CTRL_AUTO] && tick100);
    assign rif.key   = key;
    assign rif.ready = rec_ready;

    kdrf_ser u_ser (
        .clk   (clk),
        .rst_n (rst_n),
        .rif   (rif)
    );

    // Register writes; send bit is a strobe and never stored
    always_comb begin
        next_ctrl       = ctrl;
        next_nlim       = nlim;
        next_plim       = plim;
        next_det_reload = det_reload;
        next_key        = key;
        next_imask      = imask;
        if (wr) begin
            case (wb_adr_i)
                `KDRF_REG_CTRL:  next_ctrl = wb_dat_i[2:0] & 3'h5;
                `KDRF_REG_NLIM:  next_nlim = wb_dat_i[6:0];
                `KDRF_REG_PLIM:  next_plim = wb_dat_i[6:0];
                `KDRF_REG_NTIME: next_det_reload[0] = wb_dat_i[7:0];
                `KDRF_REG_PTIME: next_det_reload[1] = wb_dat_i[7:0];
                `KDRF_REG_KEY:   begin
                    if (wb_dat_i[5:0] <= `KDRF_KEY_MAX) begin
                        next_key = wb_dat_i[5:0];
                    end
                end
                `KDRF_REG_MASK:  next_imask = wb_dat_i[`KDRF_IRQ_W-1:0];
                default:         ;
            endcase
        end
    end

    // Sticky events, write one to clear; a new event wins over its clear
    assign events = {rif.done, drift_hit, expire[1], expire[0]};
    always_comb begin
        next_istat = istat;
        if (wr && wb_adr_i == `KDRF_REG_IRQ) begin
            next_istat = istat & ~wb_dat_i[`KDRF_IRQ_W-1:0];
        end
        next_istat = next_istat | events;
        next_irq   = |(next_istat & imask);
    end

    // Read mux and single-cycle acknowledge; unmapped reads return zero
    always_comb begin
        next_ack   = req;
        next_rdata = rdata;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `KDRF_REG_CTRL:  next_rdata = {29'h0, ctrl};
                `KDRF_REG_NLIM:  next_rdata = {25'h0, nlim};
                `KDRF_REG_PLIM:  next_rdata = {25'h0, plim};
                `KDRF_REG_NTIME: next_rdata = {24'h0, det_reload[0]};
                `KDRF_REG_PTIME: next_rdata = {24'h0, det_reload[1]};
                `KDRF_REG_KEY:   next_rdata = {26'h0, key};
                `KDRF_REG_STAT:  next_rdata = {7'h0, rif.busy,
                                               det_time[1], det_time[0],
                                               drift};
                `KDRF_REG_IRQ:   next_rdata = {28'h0, istat};
                `KDRF_REG_MASK:  next_rdata = {28'h0, imask};
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // All block state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack           <= 1'b0;
            rdata         <= 32'h0000_0000;
            ctrl          <= `KDRF_CTRL_RST;
            nlim          <= `KDRF_NLIM_RST;
            plim          <= `KDRF_PLIM_RST;
            det_reload[0] <= `KDRF_NTIME_RST;
            det_reload[1] <= `KDRF_PTIME_RST;
            key           <= `KDRF_KEY_RST;
            istat         <= 4'h0;
            imask         <= 4'h0;
            irq_q         <= 1'b0;
            div           <= 32'h0000_0000;
            sub           <= 3'h0;
            det_time[0]   <= `KDRF_NTIME_RST;
            det_time[1]   <= `KDRF_PTIME_RST;
            drift         <= 8'sh00;
            recal_q       <= 1'b0;
        end else begin
            ack        <= next_ack;
            rdata      <= next_rdata;
            ctrl       <= next_ctrl;
            nlim       <= next_nlim;
            plim       <= next_plim;
            det_reload <= next_det_reload;
            key        <= next_key;
            istat      <= next_istat;
            imask      <= next_imask;
            irq_q      <= next_irq;
            div        <= next_div;
            sub        <= next_sub;
            det_time   <= next_det_time;
            drift      <= next_drift;
            recal_q    <= any_hit;
        end
    end

    assign wb_ack_o  = ack;
    assign wb_dat_o  = rdata;
    assign irq       = irq_q;
    assign recal     = recal_q;
    assign rec_data  = rif.data;
    assign rec_valid = rif.valid;
    assign rec_pos   = rif.pos;
    assign rec_last  = rif.last;

endmodule : kdrf_top

`default_nettype wire
